//--- hdl/miimac_pkg.sv
// shared constants and types for the nibble-wide media interface mac
package miimac_pkg;
  localparam int unsigned REF_CLK_HZ   = 25000000;
  localparam int unsigned NIB_W        = 4;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam logic [4:0]  PRE_NIBBLES  = 5'h0F;
  localparam logic [3:0]  PRE_NIBBLE   = 4'h5;
  localparam logic [3:0]  SFD_HI       = 4'hD;
  localparam logic [7:0]  FLAG_OCTET   = 8'h5D;
  localparam logic [4:0]  IFG_NIBBLES  = 5'h18;
  localparam logic [4:0]  JAM_NIBBLES  = 5'h08;
  localparam logic [3:0]  JAM_NIBBLE   = 4'h5;
  localparam int unsigned SLOT_SHIFT   = 7;
  localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY     = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE  = 32'hDEBB20E3;
  localparam logic [7:0]  LFSR_SEED    = 8'hA5;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } miimac_byte_t;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
  } miimac_rxpins_t;

  typedef enum {TX_IDLE, TX_PRE, TX_DATA, TX_CRC, TX_JAM, TX_FLUSH, TX_BACKOFF, TX_IFG}
    miimac_txst_t;
  typedef enum {RX_IDLE, RX_HUNT, RX_DATA, RX_SKIP} miimac_rxst_t;
endpackage : miimac_pkg

//--- hdl/miimac_top.sv
// nibble-wide media interface mac: transmit framing, receive framing, fifo
`timescale 1ns/100ps

module miimac_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] memFf [DEPTH];
  logic [AW-1:0]    wrPtrFf;
  logic [AW-1:0]    rdPtrFf;
  logic [AW:0]      cntFf;
  logic [AW:0]      nxt_cnt;
  wire              doWr = inValid && inReady;
  wire              doRd = outValid && outReady;

  assign nxt_cnt = cntFf + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
  assign outData = memFf[rdPtrFf];

  always_ff @(posedge ref_clk) begin
    if (doWr) memFf[wrPtrFf] <= inData;
  end

  // flags registered from the next count so both sides see honest full/empty
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wrPtrFf  <= '0;
      rdPtrFf  <= '0;
      cntFf    <= '0;
      inReady  <= 1'b0;
      outValid <= 1'b0;
    end else begin
      if (doWr) wrPtrFf <= (wrPtrFf == AW'(DEPTH - 1)) ? '0 : wrPtrFf + 1'b1;
      if (doRd) rdPtrFf <= (rdPtrFf == AW'(DEPTH - 1)) ? '0 : rdPtrFf + 1'b1;
      cntFf    <= nxt_cnt;
      inReady  <= nxt_cnt != (AW+1)'(DEPTH);
      outValid <= nxt_cnt != '0;
    end
  end
endmodule : miimac_fifo

module miimac_top
  import miimac_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       external_phy_select,
  input  wire logic       tx_nibble_clk,
  input  wire logic       rx_nibble_clk,
  output logic            intTxEnable,
  output logic [3:0]      intTxd,
  input  wire logic       intRxDv,
  input  wire logic       intRxEr,
  input  wire logic [3:0] intRxd,
  input  wire logic       intCarrierSense,
  input  wire logic       intCollision,
  output logic            tx_enable_out,
  output logic [3:0]      extTxd,
  input  wire logic       extRxDv,
  input  wire logic       extRxEr,
  input  wire logic [3:0] extRxd,
  input  wire logic       carrier_sense_in,
  input  wire logic       collision_in,
  input  wire logic       txByteValid,
  input  wire logic [7:0] txByteData,
  input  wire logic       txByteLast,
  output logic            txByteReady,
  output logic            txDone,
  output logic            txCollision,
  output logic            txUnderrun,
  output logic            rxByteValid,
  output logic [7:0]      rxByte,
  output logic            rxFrameEnd,
  output logic            rxFrameGood,
  output logic            rxCrcError
);
  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crcByte

  // synchronisers: first stage feeds only the second
  logic [1:0]     extSelSy;
  logic [2:0]     txClkSy;
  logic [2:0]     rxClkSy;
  logic [1:0]     crsSy;
  logic [1:0]     colSy;
  miimac_rxpins_t rxPinsS1;
  miimac_rxpins_t rxPinsS2;
  wire            useExt = extSelSy[1];
  miimac_rxpins_t rxPinsRaw;
  assign rxPinsRaw = useExt ? {extRxDv, extRxEr, extRxd} : {intRxDv, intRxEr, intRxd};
  wire crsRaw = useExt ? carrier_sense_in : intCarrierSense;
  wire colRaw = useExt ? collision_in : intCollision;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      extSelSy <= '0;
      txClkSy  <= '0;
      rxClkSy  <= '0;
      crsSy    <= '0;
      colSy    <= '0;
      rxPinsS1 <= '0;
      rxPinsS2 <= '0;
    end else begin
      extSelSy <= {extSelSy[0], external_phy_select};
      txClkSy  <= {txClkSy[1:0], tx_nibble_clk};
      rxClkSy  <= {rxClkSy[1:0], rx_nibble_clk};
      crsSy    <= {crsSy[0], crsRaw};
      colSy    <= {colSy[0], colRaw};
      rxPinsS1 <= rxPinsRaw;
      rxPinsS2 <= rxPinsS1;
    end
  end

  wire txTick = txClkSy[1] && !txClkSy[2];
  wire rxTick = rxClkSy[1] && !rxClkSy[2];
  wire crs    = crsSy[1];
  wire col    = colSy[1];

  // transmit side
  miimac_byte_t fifoOut;
  logic         fifoValid;
  logic         fifoPop;
  miimac_fifo #(.WIDTH($bits(miimac_byte_t)), .DEPTH(FIFO_DEPTH)) uFifo (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .inValid  (txByteValid),
    .inReady  (txByteReady),
    .inData   ({txByteLast, txByteData}),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoOut)
  );

  miimac_txst_t txStFf;
  logic [4:0]   txCntFf;
  logic [10:0]  boffCntFf;
  logic         hiNibFf;
  logic [31:0]  txCrcFf;
  logic [7:0]   lfsrFf;
  logic         txEnFf;
  logic         flushFf;
  logic [3:0]   txdFf;
  wire  [31:0]  txFcs   = ~txCrcFf;
  wire          inFrame = txStFf == TX_PRE || txStFf == TX_DATA || txStFf == TX_CRC;
  wire          colHit  = txTick && col && inFrame;
  // drop the remainder of an aborted frame one byte per cycle
  assign fifoPop = (txStFf == TX_FLUSH && fifoValid)
                 || (txTick && txStFf == TX_DATA && hiNibFf && !colHit);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) lfsrFf <= LFSR_SEED;
    else lfsrFf <= {lfsrFf[6:0], lfsrFf[7] ^ lfsrFf[5] ^ lfsrFf[4] ^ lfsrFf[3]};
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txStFf      <= TX_IDLE;
      txCntFf     <= '0;
      boffCntFf   <= '0;
      hiNibFf     <= 1'b0;
      txCrcFf     <= CRC_INIT;
      txEnFf      <= 1'b0;
      flushFf     <= 1'b0;
      txdFf       <= '0;
      txDone      <= 1'b0;
      txCollision <= 1'b0;
      txUnderrun  <= 1'b0;
    end else begin
      txDone      <= 1'b0;
      txCollision <= 1'b0;
      txUnderrun  <= 1'b0;
      if (colHit) begin
        txStFf      <= TX_JAM;
        txCntFf     <= JAM_NIBBLES - 5'h01;
        txEnFf      <= 1'b1;
        txdFf       <= JAM_NIBBLE;
        txCollision <= 1'b1;
        // in the crc phase every byte has already left the fifo
        flushFf     <= txStFf != TX_CRC;
      end else if (txStFf == TX_FLUSH) begin
        if (fifoValid && fifoOut.last) txStFf <= TX_BACKOFF;
        else if (!fifoValid) txStFf <= TX_BACKOFF;
      end else if (txTick) begin
        case (txStFf)
          TX_IDLE: begin
            // defer while the cable is busy
            if (fifoValid && !crs) begin
              txStFf  <= TX_PRE;
              txCntFf <= PRE_NIBBLES - 5'h01;
              txEnFf  <= 1'b1;
              txdFf   <= PRE_NIBBLE;
              txCrcFf <= CRC_INIT;
            end
          end
          TX_PRE: begin
            txCntFf <= txCntFf - 5'h01;
            txdFf   <= (txCntFf == '0) ? SFD_HI : PRE_NIBBLE;
            if (txCntFf == '0) begin
              txStFf  <= TX_DATA;
              hiNibFf <= 1'b0;
            end
          end
          TX_DATA: begin
            if (!hiNibFf && !fifoValid) begin
              txStFf     <= TX_JAM;
              txCntFf    <= JAM_NIBBLES - 5'h01;
              txdFf      <= JAM_NIBBLE;
              txUnderrun <= 1'b1;
              flushFf    <= 1'b1;
            end else if (!hiNibFf) begin
              txdFf   <= fifoOut.data[3:0];
              txCrcFf <= crcByte(txCrcFf, fifoOut.data);
              hiNibFf <= 1'b1;
            end else begin
              txdFf   <= fifoOut.data[7:4];
              hiNibFf <= 1'b0;
              if (fifoOut.last) begin
                txStFf  <= TX_CRC;
                txCntFf <= 5'h07;
              end
            end
          end
          TX_CRC: begin
            txdFf   <= txFcs[4*(3'h7-txCntFf[2:0]) +: 4];
            txCntFf <= txCntFf - 5'h01;
            if (txCntFf == '0) begin
              txStFf  <= TX_IFG;
              txCntFf <= IFG_NIBBLES - 5'h01;
            end
          end
          TX_JAM: begin
            txCntFf <= txCntFf - 5'h01;
            if (txCntFf == '0) begin
              txEnFf    <= 1'b0;
              txdFf     <= '0;
              // random slot count; no retry, software resends
              boffCntFf <= {lfsrFf[3:0], 7'h00};
              txStFf    <= flushFf ? TX_FLUSH : TX_BACKOFF;
            end
          end
          TX_BACKOFF: begin
            if (boffCntFf == '0) begin
              txStFf  <= TX_IFG;
              txCntFf <= IFG_NIBBLES - 5'h01;
            end else if (!crs) begin
              boffCntFf <= boffCntFf - 11'h001;
            end
          end
          TX_IFG: begin
            if (txCntFf == '0) txStFf <= TX_IDLE;
            else txCntFf <= txCntFf - 5'h01;
          end
          default: txStFf <= TX_IDLE;
        endcase
        if (txStFf == TX_CRC && txCntFf == '0) begin
          txDone <= 1'b1;
        end
        // first gap tick: the last crc nibble now stands on the pins
        if (txStFf == TX_IFG) begin
          txEnFf <= 1'b0;
          txdFf  <= '0;
        end
      end
    end
  end

  // enable falls on the edge after the last crc nibble was put out
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_enable_out <= 1'b0;
      extTxd        <= '0;
      intTxEnable   <= 1'b0;
      intTxd        <= '0;
    end else if (txTick) begin
      tx_enable_out <= useExt && txEnFf;
      extTxd        <= useExt ? txdFf : 4'h0;
      intTxEnable   <= !useExt && txEnFf;
      intTxd        <= useExt ? 4'h0 : txdFf;
    end
  end

  // receive side, advances only on rx clock edges
  miimac_rxst_t rxStFf;
  logic [3:0]   prevNibFf;
  logic         rxHiFf;
  logic         rxErrFf;
  logic [31:0]  rxCrcFf;
  wire  [3:0]   rxNib  = rxPinsS2.d;
  wire  [7:0]   rxFull = {rxNib, prevNibFf};
  // flag matched in arrival order: earlier nibble is the high digit
  wire  [7:0]   rxPair = {prevNibFf, rxNib};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxStFf      <= RX_IDLE;
      prevNibFf   <= '0;
      rxHiFf      <= 1'b0;
      rxErrFf     <= 1'b0;
      rxCrcFf     <= CRC_INIT;
      rxByteValid <= 1'b0;
      rxByte      <= '0;
      rxFrameEnd  <= 1'b0;
      rxFrameGood <= 1'b0;
      rxCrcError  <= 1'b0;
    end else begin
      rxByteValid <= 1'b0;
      rxFrameEnd  <= 1'b0;
      if (rxTick) begin
        prevNibFf <= rxNib;
        case (rxStFf)
          RX_IDLE: begin
            if (rxPinsS2.dv) begin
              rxStFf  <= RX_HUNT;
              rxErrFf <= rxPinsS2.er;
            end
          end
          RX_HUNT: begin
            if (!rxPinsS2.dv) begin
              rxStFf <= RX_IDLE;
            end else if (rxPair == FLAG_OCTET) begin
              rxStFf  <= RX_DATA;
              rxHiFf  <= 1'b0;
              rxCrcFf <= CRC_INIT;
            end
            if (rxPinsS2.er) rxErrFf <= 1'b1;
          end
          RX_DATA: begin
            if (!rxPinsS2.dv) begin
              rxStFf      <= RX_IDLE;
              rxFrameEnd  <= 1'b1;
              rxFrameGood <= !rxErrFf && !rxHiFf && rxCrcFf == CRC_RESIDUE;
              rxCrcError  <= rxErrFf || rxCrcFf != CRC_RESIDUE;
            end else begin
              rxHiFf <= !rxHiFf;
              if (rxPinsS2.er) rxErrFf <= 1'b1;
              if (rxHiFf) begin
                rxByte      <= rxFull;
                rxByteValid <= 1'b1;
                rxCrcFf     <= crcByte(rxCrcFf, rxFull);
              end
            end
          end
          default: rxStFf <= RX_IDLE;
        endcase
      end
    end
  end
endmodule : miimac_top

//--- dv/miimac_chk.sv
// assertion checker on the top ports of the media interface mac
`timescale 1ns/100ps
module miimac_chk (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       external_phy_select,
  input wire logic       tx_nibble_clk,
  input wire logic       tx_enable_out,
  input wire logic [3:0] extTxd,
  input wire logic       intTxEnable,
  input wire logic [3:0] intTxd,
  input wire logic       extRxDv,
  input wire logic       extRxEr,
  input wire logic       carrier_sense_in,
  input wire logic       collision_in,
  input wire logic       txCollision,
  input wire logic       rxByteValid,
  input wire logic       rxFrameEnd,
  input wire logic       rxFrameGood,
  input wire logic       rxCrcError
);
  logic [1:0] tcs_ff;
  logic [3:0] sinceRise_ff;
  logic [5:0] crsCnt_ff;
  logic       errSeen_ff;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // saturating counts, so a long idle cannot wrap into a false pass
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tcs_ff       <= 2'h0;
      sinceRise_ff <= 4'hF;
      crsCnt_ff    <= 6'h00;
      errSeen_ff   <= 1'b0;
    end else begin
      tcs_ff       <= {tcs_ff[0], tx_nibble_clk};
      sinceRise_ff <= (tcs_ff == 2'h1) ? 4'h0 : sinceRise_ff + {3'h0, sinceRise_ff != 4'hF};
      crsCnt_ff    <= carrier_sense_in ? crsCnt_ff + {5'h0, crsCnt_ff != 6'h3F} : 6'h00;
      errSeen_ff   <= (extRxDv && extRxEr) || (errSeen_ff && !rxFrameEnd);
    end
  end
  sequence s_col_seen;
    ##[1:40] txCollision;
  endsequence
  sequence s_jam_done;
    ##[1:160] !tx_enable_out;
  endsequence
  a_txen_pre: assert property ($rose(tx_enable_out) |-> extTxd == 4'h5)
    else $error("tx enable rose without preamble nibble");
  a_tx_on_tick: assert property (($changed(tx_enable_out) || $changed(extTxd))
    |-> sinceRise_ff <= 4'h5) else $error("tx pins moved away from a tx clock rise");
  a_txen_gap: assert property ($fell(tx_enable_out) |=> !tx_enable_out [*8])
    else $error("tx enable back too soon");
  a_col_abort: assert property ($rose(collision_in) && tx_enable_out
    |-> s_col_seen ##0 s_jam_done) else $error("collision not handled");
  a_col_sync: assert property ($rose(collision_in) |-> !txCollision [*2])
    else $error("collision used before synchronising");
  a_defer_crs: assert property ($rose(tx_enable_out) |-> crsCnt_ff < 6'h20)
    else $error("transmit started under carrier");
  a_rxer_crc: assert property (rxFrameEnd && errSeen_ff |=> rxCrcError && !rxFrameGood)
    else $error("errored frame not reported as crc error");
  a_flags_excl: assert property (rxFrameEnd |=> !(rxFrameGood && rxCrcError))
    else $error("frame both good and bad");
  a_byte_pulse: assert property (rxByteValid |=> !rxByteValid [*8])
    else $error("rx bytes faster than rx clock allows");
  a_int_quiet: assert property (external_phy_select && $past(external_phy_select, 12)
    |-> !intTxEnable && intTxd == 4'h0) else $error("internal tx pins active");
endmodule : miimac_chk

bind miimac_top miimac_chk u_chk (.ref_clk, .nrst, .external_phy_select, .tx_nibble_clk,
  .tx_enable_out, .extTxd, .intTxEnable, .intTxd, .extRxDv, .extRxEr, .carrier_sense_in,
  .collision_in, .txCollision, .rxByteValid, .rxFrameEnd, .rxFrameGood, .rxCrcError);

//--- dv/miimac_phy.sv
// phy stand-in: nibble clocks, tx capture, rx frame source, carrier and collision
`timescale 1ns/100ps
module miimac_phy (
  input  wire logic       txEn,
  input  wire logic [3:0] txd,
  output logic            txClk,
  output logic            rxClk,
  output logic            rxDv,
  output logic            rxEr,
  output logic [3:0]      rxd,
  output logic            crs,
  output logic            col
);
  logic       crsForce;
  logic       rxBusy;
  logic [3:0] txQ[$];
  initial begin
    {crsForce, rxBusy, col, rxDv, rxEr, rxd} = 9'h000;
    txClk = 1'b0;
    #7;
    forever #160 txClk = ~txClk;
  end
  // odd offset puts every rx clock edge at a fixed phase, 1ns after a system clock rise
  initial begin
    rxClk = 1'b0;
    #61;
    forever #160 rxClk = ~rxClk;
  end
  assign crs = crsForce || txEn || rxDv || col;
  always @(posedge txClk) if (txEn) txQ.push_back(txd);
  // idle data lines keep changing, so a stale nibble can never look valid
  always @(negedge rxClk) if (!rxBusy) rxd <= ~rxd;
  task automatic rxSend(input logic [63:0] d, input int n, input int erAt);
    rxBusy = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge rxClk);
      rxDv = 1'b1;
      rxd = d[4*i+:4];
      rxEr = (i == erAt);
    end
    @(negedge rxClk);
    rxDv = 1'b0;
    rxEr = 1'b0;
    rxBusy = 1'b0;
  endtask : rxSend
endmodule : miimac_phy

//--- dv/miimac_tb_top.sv
// self-checking bench for the media interface mac
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (e)); end end
module miimac_tb_top;
  import miimac_pkg::*;
  localparam logic [63:0] TX_PAY = 64'hF0E1D2C3B4A59687;
  localparam logic [15:0] RX_PAY = 16'hA712;
  logic       ref_clk;
  logic       nrst;
  logic       external_phy_select;
  logic       txByteValid;
  logic [7:0] txByteData;
  logic       txByteLast;
  logic       txByteReady, txDone, txCollision, rxByteValid, rxFrameEnd;
  logic       rxFrameGood, rxCrcError, tx_enable_out, intTxEnable, txUnderrun;
  logic [3:0] extTxd, intTxd;
  logic [7:0] rxByte;
  logic       txClk, rxClk, rxDv, rxEr, crs, col;
  logic [3:0] rxd;
  logic       doneSeen, colSeen, endSeen, unSeen;
  logic [7:0] rxQ[$];
  int         n_mismatch, n_tests;

  miimac_top DUT (.ref_clk, .nrst, .external_phy_select, .tx_nibble_clk(txClk),
    .rx_nibble_clk(rxClk), .intTxEnable, .intTxd, .intRxDv(rxDv), .intRxEr(rxEr),
    .intRxd(rxd), .intCarrierSense(crs), .intCollision(col), .tx_enable_out, .extTxd,
    .extRxDv(rxDv), .extRxEr(rxEr), .extRxd(rxd), .carrier_sense_in(crs),
    .collision_in(col), .txByteValid, .txByteData, .txByteLast, .txByteReady, .txDone,
    .txCollision, .txUnderrun, .rxByteValid, .rxByte, .rxFrameEnd, .rxFrameGood,
    .rxCrcError);
  miimac_phy phy (.txEn(tx_enable_out), .txd(extTxd), .txClk, .rxClk, .rxDv, .rxEr, .rxd,
    .crs, .col);

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;
  // pulses are caught mid-cycle, away from the edge that launches them
  always @(negedge ref_clk) begin
    if (txDone === 1'b1) doneSeen = 1'b1;
    if (txCollision === 1'b1) colSeen = 1'b1;
    if (txUnderrun === 1'b1) unSeen = 1'b1;
    if (rxFrameEnd === 1'b1) endSeen = 1'b1;
    if (rxByteValid === 1'b1) rxQ.push_back(rxByte);
  end

  function automatic logic [31:0] fcs(input logic [63:0] d, input int n);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 8 * n; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? CRC_POLY : 32'h0);
    return ~c;
  endfunction : fcs

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic put(input logic [7:0] d, input logic l);
    tick(1);
    txByteValid = 1'b1;
    txByteData = d;
    txByteLast = l;
    while (txByteReady !== 1'b1) tick(1);
    tick(1);
    txByteValid = 1'b0;
  endtask : put

  task automatic t_tx_full;
    logic [127:0] f;
    f = {32'h0, fcs(TX_PAY, 8), TX_PAY};
    doneSeen = 1'b0;
    phy.txQ.delete();
    phy.crsForce = 1'b1;
    tick(40);
    for (int i = 0; i < 8; i++) put(TX_PAY[8*i+:8], i == 7);
    tick(2);
    `CHK(txByteReady, 1'b0)
    `CHK(tx_enable_out, 1'b0)
    phy.crsForce = 1'b0;
    for (int k = 0; k < 600 && doneSeen !== 1'b1; k++) tick(1);
    tick(16);
    `CHK(doneSeen, 1'b1)
    `CHK(phy.txQ.size(), 40)
    `CHK(unSeen, 1'b0)
    for (int i = 0; i < 40; i++)
      `CHK(phy.txQ[i], (i < 15) ? 4'h5 : (i == 15) ? 4'hD : f[4*(i-16)+:4])
    $display("t_tx_full done");
  endtask : t_tx_full

  task automatic t_rx(input logic er);
    logic [63:0] f;
    f = {fcs({48'h0, RX_PAY}, 2), RX_PAY, 8'hD5, 8'hA3};
    rxQ.delete();
    endSeen = 1'b0;
    phy.rxSend(f, 16, er ? 9 : -1);
    for (int k = 0; k < 200 && endSeen !== 1'b1; k++) tick(1);
    tick(2);
    `CHK(endSeen, 1'b1)
    `CHK(rxFrameGood, !er)
    `CHK(rxCrcError, er)
    `CHK(rxQ.size(), 6)
    if (!er) for (int i = 0; i < 6; i++) `CHK(rxQ[i], f[16+8*i+:8])
    $display("t_rx done");
  endtask : t_rx

  // internal pins carry the frame while the external ones stay quiet
  task automatic t_int;
    doneSeen = 1'b0;
    unSeen = 1'b0;
    external_phy_select = 1'b0;
    tick(4);
    put(8'h3C, 1'b1);
    for (int k = 0; k < 400 && intTxEnable !== 1'b1; k++) tick(1);
    `CHK(intTxEnable, 1'b1)
    `CHK(intTxd, 4'h5)
    `CHK(tx_enable_out, 1'b0)
    for (int k = 0; k < 600 && doneSeen !== 1'b1; k++) tick(1);
    tick(24);
    `CHK(doneSeen, 1'b1)
    `CHK(intTxEnable, 1'b0)
    `CHK(unSeen, 1'b0)
    external_phy_select = 1'b1;
    tick(4);
    $display("t_int done");
  endtask : t_int

  task automatic t_col;
    colSeen = 1'b0;
    doneSeen = 1'b0;
    for (int i = 0; i < 4; i++) put(TX_PAY[8*i+:8], i == 3);
    for (int k = 0; k < 400 && tx_enable_out !== 1'b1; k++) tick(1);
    tick(40);
    phy.col = 1'b1;
    for (int k = 0; k < 300 && tx_enable_out !== 1'b0; k++) tick(1);
    phy.col = 1'b0;
    `CHK(colSeen, 1'b1)
    `CHK(tx_enable_out, 1'b0)
    tick(400);
    `CHK(doneSeen, 1'b0)
    $display("t_col done");
  endtask : t_col

  task automatic end_of_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    {nrst, txByteValid, txByteData, txByteLast, doneSeen, colSeen, endSeen, unSeen} = 15'h0;
    external_phy_select = 1'b1;
    n_mismatch = 0;
    n_tests = 0;
    tick(10);
    nrst = 1'b1;
    tick(4);
    t_tx_full();
    t_rx(1'b0);
    t_rx(1'b1);
    t_int();
    t_col();
    end_of_test();
  end
  // whole run is under two thousand cycles; this is ample margin
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule : miimac_tb_top
